/* File: tb/mrx_link_partner.sv */
// link partner model feeding the parsed rx byte stream
`timescale 1ns/1ps
module mrx_link_partner (
  input  wire logic           clk,
  input  wire logic           rx_ready,
  output logic                rx_valid,
  output logic [7:0]          rx_data,
  output logic                rx_sof,
  output logic                rx_eof,
  output mrx_pkg::mrx_class_s rx_class,
  output logic [15:0]         rx_pause_quanta
);
  // ==========================================================
  // frame sender; a byte that never sees ready is counted here
  int n_stuck = 0;
  initial begin
    rx_valid = 0;
    rx_data = 8'hA5;
    rx_sof = 0;
    rx_eof = 0;
    rx_class = '0;
    rx_pause_quanta = 16'h0000;
  end
  // class is only valid on eof, so other beats carry its inverse
  task automatic send(input logic [7:0] b[$], input mrx_pkg::mrx_class_s c,
                      input logic [15:0] pq, input int gap);
    @(posedge clk) #1;
    foreach (b[i]) begin
      rx_valid = 1;
      rx_data = b[i];
      rx_sof = (i == 0);
      rx_eof = (i == b.size() - 1);
      rx_class = rx_eof ? c : ~c;
      rx_pause_quanta = rx_eof ? pq : ~pq;
      for (int k = 0; k < 4000; k++) begin
        @(posedge clk);
        if (rx_ready) break;
        if (k == 3999) n_stuck++;
      end
      if (gap > 0 || rx_eof) begin
        #1 rx_valid = 0;
        rx_data = ~rx_data;
        rx_sof = 0;
        rx_eof = 0;
        rx_class = ~rx_class;
        repeat (gap) @(posedge clk);
        #1;
      end else #1;
    end
  endtask
endmodule // mrx_link_partner

/* File: tb/mrx_rx_control_checker.sv */
// port checker for the rx control / tx status block, with its bind
`timescale 1ns/1ps
module mrx_rx_control_checker #(
  parameter int QDEPTH = 8
) (
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic [7:0]             reg_addr,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [1:0]             reg_be,
  input wire logic [15:0]            reg_wdata,
  input wire logic [15:0]            reg_rdata,
  input wire mrx_pkg::mrx_tx_event_s tx_evt,
  input wire logic                   full_duplex,
  input wire logic                   tx_hold,
  input wire logic                   rx_ready,
  input wire logic                   q_valid,
  input wire logic                   rx_queue_reset,
  input wire logic                   rx_running
);
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_flush_write: assert property (
    reg_wr && reg_addr == 8'h74 && reg_be[1]
    |=> rx_queue_reset == $past(reg_wdata[15])) else $error("flush lost");
  a_run_write: assert property (
    reg_wr && reg_addr == 8'h74 && reg_be[0]
    |=> rx_running == $past(reg_wdata[0])) else $error("run bit lost");
  a_flush_empty: assert property (
    rx_queue_reset |=> !q_valid) else $error("queue not empty");
  a_flush_ready: assert property (
    rx_queue_reset |-> rx_ready) else $error("flush stalls source");
  a_ctrl_read: assert property (
    reg_rd && reg_addr == 8'h74 |=> reg_rdata[15] == $past(rx_queue_reset)
    && reg_rdata[0] == $past(rx_running)) else $error("control read");
  a_unmapped_read: assert property (
    reg_rd && reg_addr != 8'h72 && reg_addr != 8'h74
    |=> reg_rdata == 16'h0000) else $error("unmapped read");
  a_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  a_status_read: assert property (
    tx_evt.done ##1 reg_rd && reg_addr == 8'h72 && !tx_evt.done
    |=> reg_rdata[5:0] == $past(tx_evt.fid, 2) && reg_rdata[11:6] == 6'h00
    && reg_rdata[15:14] == 2'h0) else $error("status word");
  a_half_nohold: assert property (
    !full_duplex ##1 !full_duplex |-> !tx_hold) else $error("half hold");
  c_tx_done: cover property (tx_evt.done);
  c_flush: cover property (rx_queue_reset && !q_valid);
  c_hold: cover property (tx_hold && full_duplex);
endmodule // mrx_rx_control_checker

bind mrx_rx_control mrx_rx_control_checker #(.QDEPTH(QDEPTH)) chk_inst (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .tx_evt(tx_evt), .full_duplex(full_duplex),
  .tx_hold(tx_hold), .rx_ready(rx_ready), .q_valid(q_valid),
  .rx_queue_reset(rx_queue_reset), .rx_running(rx_running));

/* File: tb/mrx_rx_control_tb.sv */
// self-checking bench for the rx control / tx status block
`timescale 1ns/1ps
module mrx_rx_control_tb;
  logic                   clk, reset_n, reg_wr, reg_rd, full_duplex;
  logic                   q_ready, stall, rx_valid, rx_ready, rx_sof;
  logic                   rx_eof, q_valid, tx_hold, q_rst, run;
  logic [7:0]             reg_addr, rx_data;
  logic [1:0]             reg_be;
  logic [15:0]            reg_wdata, reg_rdata, pq, ctl, rx_pause_quanta;
  mrx_pkg::mrx_tx_event_s tx_evt;
  mrx_pkg::mrx_class_s    c, rx_class;
  mrx_pkg::mrx_word_s     q_word, e;
  mrx_pkg::mrx_word_s     exp_q[$];
  logic [7:0]             b[$];
  int                     n_mismatch, n_checks, seed, k;

  mrx_rx_control #(.QDEPTH(8)) mrx_rx_control_inst (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .tx_evt(tx_evt), .full_duplex(full_duplex),
    .tx_hold(tx_hold), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .rx_class(rx_class), .rx_pause_quanta(rx_pause_quanta),
    .q_valid(q_valid), .q_ready(q_ready), .q_word(q_word),
    .rx_queue_reset(q_rst), .rx_running(run));
  mrx_link_partner mrx_link_partner_inst (
    .clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .rx_class(rx_class), .rx_pause_quanta(rx_pause_quanta));

  // ==========================================================
  // helpers
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    #1 q_ready = !stall && 1'($random(seed));
  end
  task automatic chk(input string s, input logic [15:0] x, input logic [15:0] g);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic rio(input logic [7:0] a, input logic w, input logic [15:0] d);
    reg_addr = a;
    reg_wr = w;
    reg_rd = !w;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_wr = 0;
    reg_rd = 0;
    // idle edge so back to back calls never retoggle a strobe
    @(posedge clk) #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    rio(a, 0, 16'h0000);
    chk("reg_rdata", x, reg_rdata);
  endtask
  task automatic wr(input logic [15:0] d);
    ctl = d;
    rio(8'h74, 1, d);
  endtask
  // expected keep flag of a frame under the current control word
  function automatic logic kf(mrx_pkg::mrx_class_s k, logic [15:0] r);
    logic a;
    a = k.is_bcast ? r[7] : k.is_mcast ? r[8] & k.mcast_pass : r[11] & k.da_match;
    return a && !(r[14] && k.is_udp && !k.udp_ok) && (!k.crc_err || r[9])
      && !(r[13] && k.is_tcp && !k.tcp_ok) && !(r[12] && k.is_ip && !k.ip_ok);
  endfunction
  task automatic frm(input int n, input logic on, input int gap);
    b = {};
    for (int i = 0; i < n; i++) begin
      b.push_back(8'($random(seed)));
      if (on) exp_q.push_back({b[i], i == 0, i == n - 1, kf(c, ctl)});
    end
    mrx_link_partner_inst.send(b, c, pq, gap);
  endtask
  task automatic drain();
    for (k = 0; k < 3000 && exp_q.size() > 0; k++) @(posedge clk) #1;
    chk("exp_q_left", 0, 16'(exp_q.size()));
  endtask
  task automatic conclude();
    chk("link_wait", 0, 16'(mrx_link_partner_inst.n_stuck));
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if ((q_valid & q_ready) === 1'b1) begin
      n_checks++;
      e = exp_q.size() ? exp_q.pop_front() : 'x;
      if (q_word[10:1] !== e[10:1] || (e.eof && q_word.keep !== e.keep)) begin
        n_mismatch++;
        $display("mismatch q_word exp %h got %h", e, q_word);
      end
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h758E;
    {reset_n, reg_wr, reg_rd, full_duplex, stall, q_ready} = '0;
    {reg_addr, reg_be, reg_wdata, pq, ctl, tx_evt, c} = '0;
    repeat (16) @(posedge clk);
    #1 reset_n = 1;
    reg_be = 2'b11;
    rd(8'h74, 16'h0800);
    rd(8'h72, 16'h0000);
    rd(8'h76, 16'h0000);
    reg_be = 2'b01;
    wr(16'hFFFF);
    reg_be = 2'b11;
    rd(8'h74, 16'h0881);
    rio(8'h72, 1, 16'hFFFF);
    rd(8'h72, 16'h0000);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      tx_evt = '0;
      tx_evt.start = 1;
      @(posedge clk) #1 tx_evt.start = 0;
      tx_evt.late_coll = i[0];
      @(posedge clk) #1 tx_evt.late_coll = 0;
      tx_evt.max_coll = i[1];
      tx_evt.done = 1;
      tx_evt.fid = 6'($random(seed));
      @(posedge clk) #1 {tx_evt.done, tx_evt.max_coll} = 2'b00;
      rd(8'h72, {2'b00, i[0], i[1], 6'h00, tx_evt.fid});
      tx_evt = '0;
    end
    $display("test tx status done");
    for (int i = 0; i < 40; i++) begin
      wr(16'($random(seed)) & 16'h7B80 | 16'h0001);
      c = mrx_pkg::mrx_class_s'($random(seed));
      c.is_pause = 0;
      frm(1 + i % 4, 1, i % 3);
    end
    drain();
    $display("test filters done");
    c = '0;
    c.is_bcast = 1;
    wr(16'h0880);
    chk("rx_running", 0, 16'(run));
    frm(3, 0, 0);
    wr(16'h0881);
    fork
      frm(6, 1, 1);
      begin
        repeat (3) @(posedge clk);
        #1 wr(16'h0880);
      end
    join
    wr(16'h0881);
    drain();
    $display("test run enable done");
    stall = 1;
    fork
      frm(10, 1, 0);
      begin
        repeat (12) @(posedge clk);
        #1 chk("rx_ready", 0, rx_ready);
        wr(16'h0880);
        wr(16'h8880);
        exp_q = {};
        chk("rx_queue_reset", 1, 16'(q_rst));
        @(posedge clk) #1 chk("q_valid", 0, q_valid);
      end
    join
    chk("q_valid", 0, q_valid);
    wr(16'h0880);
    wr(16'h0881);
    stall = 0;
    $display("test flush done");
    full_duplex = 1;
    wr(16'h0481);
    c.is_pause = 1;
    pq = 2;
    frm(1, 1, 0);
    @(posedge clk) #1 chk("tx_hold", 1, tx_hold);
    for (k = 0; k < 2100 && tx_hold === 1'b1; k++) @(posedge clk) #1;
    chk("pause_span", 16'(2 * mrx_pkg::QUANTUM_CYC - 1), 16'(k));
    pq = 3;
    frm(1, 1, 0);
    chk("tx_hold", 1, 16'(tx_hold));
    full_duplex = 0;
    repeat (2) @(posedge clk);
    #1 chk("tx_hold", 0, tx_hold);
    wr(16'h0881);
    drain();
    $display("test pause done");
    conclude();
  end
endmodule // mrx_rx_control_tb

/* File: verilog/mrx_pkg.sv */
// shared constants and carrier types for the rx control / tx status block
package mrx_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0]  TRANSMIT_OUTCOME_STATUS_OFF        = 8'h72;
  localparam logic [7:0]  RECEIVE_CONTROL_ONE_OFF       = 8'h74;
  localparam logic [15:0] RECEIVE_CONTROL_ONE_RESET     = 16'h0800;
  localparam logic [15:0] RECEIVE_CONTROL_ONE_MASK      = 16'hFF81;
  localparam logic [15:0] TRANSMIT_OUTCOME_STATUS_RESET      = 16'h0000;

  // ==========================================================
  // transmit_outcome_status fields
  localparam int TRANSMIT_OUTCOME_STATUS_LATE_BIT = 13;
  localparam int TRANSMIT_OUTCOME_STATUS_MAX_BIT  = 12;
  localparam int TRANSMIT_OUTCOME_STATUS_FID_LSB  = 0;
  localparam int FID_W         = 6;

  // ==========================================================
  // receive_control_one fields
  localparam int FLUSH_BIT   = 15;
  localparam int UDP_CHK_BIT = 14;
  localparam int TCP_CHK_BIT = 13;
  localparam int IP_CHK_BIT  = 12;
  localparam int PHYS_BIT    = 11;
  localparam int PAUSE_BIT   = 10;
  localparam int CRCERR_BIT  = 9;
  localparam int MCAST_BIT   = 8;
  localparam int BCAST_BIT   = 7;
  localparam int RUN_BIT     = 0;

  // ==========================================================
  // timing: one pause quantum is 512 bit times at 100 Mb/s
  localparam int CLK_MHZ          = 200;
  localparam int PAUSE_QUANTUM_NS = 5120;
  localparam int QUANTUM_CYC      = PAUSE_QUANTUM_NS * CLK_MHZ / 1000;
  localparam int QDIV_W           = $clog2(QUANTUM_CYC);

  // ==========================================================
  // carriers
  typedef struct packed {
    logic is_bcast;
    logic is_mcast;
    logic da_match;
    logic mcast_pass;
    logic crc_err;
    logic is_ip;
    logic ip_ok;
    logic is_tcp;
    logic tcp_ok;
    logic is_udp;
    logic udp_ok;
    logic is_pause;
  } mrx_class_s;

  typedef struct packed {
    logic             start;
    logic             done;
    logic             late_coll;
    logic             max_coll;
    logic [FID_W-1:0] fid;
  } mrx_tx_event_s;

  typedef struct packed {
    logic [7:0] data;
    logic       sof;
    logic       eof;
    logic       keep;
  } mrx_word_s;

  localparam int WORD_W = $bits(mrx_word_s);

endpackage

/* File: verilog/mrx_rx_control.sv */
// rx control word, tx status word, rx filter and receive queue fifo
//
// Overview of operation
// - tx status word holds last frame outcome
// - bit 13 flags late collision
// - bit 12 flags maximum collisions reached
// - bits 5:0 carry that frame's identifier
// - flush bit clears queue, resets pointer
// - bit 14 drops bad udp checksum
// - bit 13 drops bad tcp checksum
// - bit 12 drops bad ip header checksum
// - bit 11 accepts matching unicast, resets one
// - bit 10 honours pause in full duplex
// - bit 9 keeps crc error frames
// - bit 8 accepts filtered multicast
// - bit 7 accepts all broadcast
// - bit 0 runs receive, stops after frame
`timescale 1ns/1ps

module mrx_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         clear,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(D);

  // ==========================================================
  // elaboration check
  if (D < 2 || (1 << AW) != D) begin : g_bad_depth
    $error("mrx_fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } mrx_fifo_state_s;

  mrx_fifo_state_s st_r;
  mrx_fifo_state_s st_nxt;
  logic [W-1:0]    mem [D];
  logic            push;
  logic            pop;

  // ==========================================================
  // flags
  assign in_ready  = !clear && !((st_r.wr[AW] != st_r.rd[AW]) &&
                     (st_r.wr[AW-1:0] == st_r.rd[AW-1:0]));
  assign out_valid = !clear && (st_r.wr != st_r.rd);
  assign out_data  = mem[st_r.rd[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (clear) begin
      st_nxt = '0;
    end else begin
      if (push) begin
        st_nxt.wr = st_r.wr + 1'b1;
      end
      if (pop) begin
        st_nxt.rd = st_r.rd + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // storage has no reset; pointers alone say what is valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_r.wr[AW-1:0]] <= in_data;
    end
  end

endmodule // mrx_fifo

module mrx_rx_control #(
  parameter int QDEPTH = 8
) (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [1:0]              reg_be,
  input  wire logic [15:0]             reg_wdata,
  output logic [15:0]                  reg_rdata,
  // transmit engine events
  input  wire mrx_pkg::mrx_tx_event_s  tx_evt,
  input  wire logic                    full_duplex,
  output logic                         tx_hold,
  // receive stream from the mac parser
  input  wire logic                    rx_valid,
  output logic                         rx_ready,
  input  wire logic [7:0]              rx_data,
  input  wire logic                    rx_sof,
  input  wire logic                    rx_eof,
  input  wire mrx_pkg::mrx_class_s     rx_class,
  input  wire logic [15:0]             rx_pause_quanta,
  // receive queue side
  output logic                         q_valid,
  input  wire logic                    q_ready,
  output mrx_pkg::mrx_word_s           q_word,
  output logic                         rx_queue_reset,
  output logic                         rx_running
);

  typedef struct packed {
    logic [15:0]                rdata;
    logic [15:0]                ctrl;
    logic [15:0]                transmit_outcome_status;
    logic                       late_acc;
    logic                       max_acc;
    logic                       live;
    logic [15:0]                pause_q;
    logic [mrx_pkg::QDIV_W-1:0] qdiv;
  } mrx_state_s;

  mrx_state_s        st_r;
  mrx_state_s        st_nxt;
  mrx_pkg::mrx_word_s push_word;
  logic              push_valid;
  logic              fifo_ready;
  logic              beat;
  logic              start_live;
  logic              take;
  logic              keep;
  logic              flush;
  logic              honour;

  // ==========================================================
  // frame acceptance
  function automatic logic frame_pass(input mrx_pkg::mrx_class_s c,
                                      input logic [15:0] k);
    logic addr_ok;
    logic chk_bad;
    addr_ok = 1'b0;
    chk_bad = 1'b0;
    if (c.is_bcast) begin
      addr_ok = k[mrx_pkg::BCAST_BIT];
    end else if (c.is_mcast) begin
      addr_ok = k[mrx_pkg::MCAST_BIT] && c.mcast_pass;
    end else begin
      addr_ok = k[mrx_pkg::PHYS_BIT] && c.da_match;
    end
    // protocol flags gate the udp, tcp and ip checks so other frames pass
    if (k[mrx_pkg::UDP_CHK_BIT] && c.is_udp && !c.udp_ok) begin
      chk_bad = 1'b1;
    end
    if (k[mrx_pkg::TCP_CHK_BIT] && c.is_tcp && !c.tcp_ok) begin
      chk_bad = 1'b1;
    end
    if (k[mrx_pkg::IP_CHK_BIT] && c.is_ip && !c.ip_ok) begin
      chk_bad = 1'b1;
    end
    if (c.crc_err && !k[mrx_pkg::CRCERR_BIT]) begin
      chk_bad = 1'b1;
    end
    return addr_ok && !chk_bad;
  endfunction

  // ==========================================================
  // stream path
  assign flush  = st_r.ctrl[mrx_pkg::FLUSH_BIT];
  assign honour = st_r.ctrl[mrx_pkg::PAUSE_BIT] && full_duplex;
  // enable is sampled only at frame start, so a clear lets the
  // current frame finish
  assign start_live = rx_sof && st_r.ctrl[mrx_pkg::RUN_BIT] && !flush;
  assign take       = !flush && (st_r.live || start_live);
  assign push_valid = rx_valid && take;
  // frames not taken are sunk at full rate, never stalled
  assign rx_ready   = take ? fifo_ready : 1'b1;
  assign beat       = rx_valid && rx_ready;
  assign keep       = rx_eof && frame_pass(rx_class, st_r.ctrl);

  always_comb begin
    push_word      = '0;
    push_word.data = rx_data;
    push_word.sof  = rx_sof;
    push_word.eof  = rx_eof;
    push_word.keep = keep; // downstream commits on eof with keep
  end

  mrx_fifo #(
    .W (mrx_pkg::WORD_W),
    .D (QDEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .clear     (flush),
    .in_valid  (push_valid),
    .in_ready  (fifo_ready),
    .in_data   (push_word),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_word)
  );

  assign rx_queue_reset = flush;
  assign rx_running     = st_r.ctrl[mrx_pkg::RUN_BIT];
  assign reg_rdata      = st_r.rdata;
  assign tx_hold        = st_r.pause_q != 16'h0000;

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;

    // register writes, byte lanes honoured
    if (reg_wr && reg_addr == mrx_pkg::RECEIVE_CONTROL_ONE_OFF) begin
      if (reg_be[0]) begin
        st_nxt.ctrl[7:0] = reg_wdata[7:0] & mrx_pkg::RECEIVE_CONTROL_ONE_MASK[7:0];
      end
      if (reg_be[1]) begin
        // flush stays set until software clears it
        st_nxt.ctrl[15:8] = reg_wdata[15:8] &
                            mrx_pkg::RECEIVE_CONTROL_ONE_MASK[15:8];
      end
    end

    // register reads, unmapped reads return zero
    if (reg_rd) begin
      unique case (reg_addr)
        mrx_pkg::TRANSMIT_OUTCOME_STATUS_OFF:  st_nxt.rdata = st_r.transmit_outcome_status;
        mrx_pkg::RECEIVE_CONTROL_ONE_OFF: st_nxt.rdata = st_r.ctrl;
        default:            st_nxt.rdata = 16'h0000;
      endcase
    end

    // collision outcome gathered over one frame
    if (tx_evt.start) begin
      st_nxt.late_acc = 1'b0;
      st_nxt.max_acc  = 1'b0;
    end
    if (tx_evt.late_coll) begin
      st_nxt.late_acc = 1'b1;
    end
    if (tx_evt.max_coll) begin
      st_nxt.max_acc = 1'b1;
    end
    if (tx_evt.done) begin
      // whole word replaced at once so id and flags match
      st_nxt.transmit_outcome_status = mrx_pkg::TRANSMIT_OUTCOME_STATUS_RESET;
      st_nxt.transmit_outcome_status[mrx_pkg::TRANSMIT_OUTCOME_STATUS_FID_LSB +: mrx_pkg::FID_W] = tx_evt.fid;
      st_nxt.transmit_outcome_status[mrx_pkg::TRANSMIT_OUTCOME_STATUS_LATE_BIT] =
        st_r.late_acc || tx_evt.late_coll;
      st_nxt.transmit_outcome_status[mrx_pkg::TRANSMIT_OUTCOME_STATUS_MAX_BIT] =
        st_r.max_acc || tx_evt.max_coll;
    end

    // frame tracking
    if (flush) begin
      st_nxt.live = 1'b0;
    end else if (beat) begin
      if (rx_eof) begin
        st_nxt.live = 1'b0;
      end else if (start_live) begin
        st_nxt.live = 1'b1;
      end
    end

    // pause timer, counted in quanta by a divider enable
    if (!honour) begin
      st_nxt.pause_q = 16'h0000; // no meaning in half duplex
      st_nxt.qdiv    = '0;
    end else if (beat && push_valid && keep && rx_class.is_pause) begin
      st_nxt.pause_q = rx_pause_quanta;
      st_nxt.qdiv    = '0;
    end else if (st_r.pause_q != 16'h0000) begin
      if (st_r.qdiv == mrx_pkg::QDIV_W'(mrx_pkg::QUANTUM_CYC - 1)) begin
        st_nxt.qdiv    = '0;
        st_nxt.pause_q = st_r.pause_q - 16'h0001;
      end else begin
        st_nxt.qdiv = st_r.qdiv + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r      <= '0;
      st_r.ctrl <= mrx_pkg::RECEIVE_CONTROL_ONE_RESET;
      st_r.transmit_outcome_status <= mrx_pkg::TRANSMIT_OUTCOME_STATUS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // mrx_rx_control
